// ---- rtl/gmc_pkg.sv ----
// Constants for the gauge measurement calibration block.
// Assumes a single clock domain and a byte-addressed constant store.
package gmc_pkg;
	// Register byte offsets in the constant store
	localparam logic [7:0] OFF_CHECK_ONE = 8'h00;
	localparam logic [7:0] OFF_SPEC_INFO = 8'h14;
	localparam logic [7:0] OFF_BUILD_DATE = 8'h16;
	localparam logic [7:0] OFF_UNIT_NUMBER = 8'h18;
	localparam logic [7:0] OFF_MAKER_LEN = 8'h20;
	localparam logic [7:0] OFF_PART_LEN = 8'h30;
	localparam logic [7:0] OFF_CHEM_LEN = 8'h40;
	localparam logic [7:0] OFF_MDATA_LEN = 8'h50;
	localparam logic [7:0] OFF_CONTROL_MODE = 8'h51;
	localparam logic [7:0] OFF_CC_OFFSET = 8'h5e;
	localparam logic [7:0] OFF_TEMP_CORR = 8'h61;
	localparam logic [7:0] OFF_ZERO_TRIM = 8'h62;
	localparam logic [7:0] OFF_CELL2_TRIM = 8'h63;
	localparam logic [7:0] OFF_CELL3_TRIM = 8'h64;
	localparam logic [7:0] OFF_CELL4_TRIM = 8'h65;
	localparam logic [7:0] OFF_VOLT_SCALE = 8'h66;
	localparam logic [7:0] OFF_CURR_SCALE = 8'h68;
	localparam logic [7:0] OFF_CC_SCALE = 8'h6a;
	localparam logic [7:0] OFF_CHECK_TWO = 8'h7e;
	localparam logic [7:0] OFF_PACK_CONFIG = 8'h3f;
	// Read-only result words (block state)
	localparam logic [7:0] OFF_RES_PACK = 8'h80;
	localparam logic [7:0] OFF_RES_CELL1 = 8'h82;
	localparam logic [7:0] OFF_RES_CELL2 = 8'h84;
	localparam logic [7:0] OFF_RES_CELL3 = 8'h86;
	localparam logic [7:0] OFF_RES_CELL4 = 8'h88;
	localparam logic [7:0] OFF_RES_CURR = 8'h8a;
	localparam logic [7:0] OFF_RES_TEMP = 8'h8c;
	localparam logic [7:0] OFF_RES_STATUS = 8'h8e;
	// Control mode bit positions
	localparam int BIT_SUPPRESS = 0;
	localparam int BIT_STYLE = 2;
	localparam int BIT_LEDS = 3;
	localparam int BIT_CKSUM = 4;
	// Pack configuration cell-count field
	localparam int BIT_CNT_LO = 0;
	localparam int BIT_CNT_HI = 1;
	localparam logic [1:0] CNT_STACK = 2'h0;
	localparam logic [1:0] CNT_TWO = 2'h1;
	localparam logic [1:0] CNT_THREE = 2'h2;
	// Charge counter offset layout
	localparam int CC_MAG_W = 20;
	localparam int CC_SIGN_BIT = 20;
	// Scaling figures
	localparam int RAW_SCALE_NUM = 32768;
	localparam int RAW_SCALE_DEN = 1250;
	localparam int TRIM_WEIGHT = 8;
	localparam int NODE_SHIFT = 15;
	localparam int CURR_NUM = 1000;
	localparam int CURR_DEN = 16384;
	localparam int TEMP_WEIGHT = 10;
	// Fixed check words
	localparam logic [15:0] CHECK_ONE_VAL = 16'h3c7f;
	localparam logic [15:0] CHECK_TWO_VAL = 16'ha55a;
	// Manufacturer-access command words, values arbitrary
	localparam logic [15:0] CMD_CC_CAL = 16'h0001;
	// Calibration sequencer states
	typedef enum logic [2:0]
	{
		GMC_IDLE = 3'b001,
		GMC_ACCUM = 3'b010,
		GMC_STORE = 3'b100
	} gmc_state_e;
endpackage

// ---- rtl/gmc_calib.sv ----
// Calibration datapath and constant store for a battery gas gauge.
// Assumes raw converter samples arrive as one-cycle strobes on i_clock.
`timescale 1ns/1ps
module gmc_calib
#(
	parameter int RAW_W = 16,
	parameter int CAL_SAMPLES = 16
)
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_nrst,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// Raw converter samples, node index 0..3 is node 1..4
	input wire logic i_node_vld,
	input wire logic [1:0] i_node_idx,
	input wire logic [RAW_W-1:0] i_node_raw,
	input wire logic i_sense_vld,
	input wire logic signed [RAW_W-1:0] i_sense_raw,
	input wire logic i_temp_vld,
	input wire logic signed [15:0] i_temp_raw,
	input wire logic i_cc_vld,
	input wire logic signed [gmc_pkg::CC_MAG_W:0] i_cc_raw,
	// Maker access function command
	input wire logic i_maker_cmd_vld,
	input wire logic [15:0] i_maker_cmd,
	// Battery mode broadcast request from firmware writes
	input wire logic i_mode_bcast_en,
	// Control outputs
	output logic o_charger_checksum_enable,
	output logic o_five_leds,
	output logic o_smart_charger_learn,
	output logic o_broadcast_enable,
	output logic o_image_valid,
	output logic o_cal_busy
);
	localparam int CC_W = gmc_pkg::CC_MAG_W + 1;
	localparam int MAG_W = gmc_pkg::CC_MAG_W;
	localparam int WIDE = 64;

	// Elaboration checks
	if (RAW_W < 8 || RAW_W > 24)
		$error("RAW_W out of range");
	if (CAL_SAMPLES < 1 || CAL_SAMPLES > 65536)
		$error("CAL_SAMPLES out of range");

	////////////////////////////////////////////////////////////////
	// Constant store
	logic [7:0] mem_r [0:127];
	logic [15:0] rdata_r;

	// Word and byte views of the store
	function automatic logic [15:0] word_at(input logic [7:0] a);
		word_at = {mem_r[a[6:0]+7'h01], mem_r[a[6:0]]};
	endfunction

	logic [7:0] ctrl;
	logic [1:0] cnt;
	logic signed [WIDE-1:0] zero_trim;
	logic signed [WIDE-1:0] trim [0:3];
	logic signed [WIDE-1:0] vscale;
	logic signed [WIDE-1:0] iscale;
	always_comb
	begin
		ctrl = mem_r[gmc_pkg::OFF_CONTROL_MODE[6:0]];
		cnt = {mem_r[gmc_pkg::OFF_PACK_CONFIG[6:0]][gmc_pkg::BIT_CNT_HI],
			mem_r[gmc_pkg::OFF_PACK_CONFIG[6:0]][gmc_pkg::BIT_CNT_LO]};
		zero_trim = WIDE'(signed'(mem_r[gmc_pkg::OFF_ZERO_TRIM[6:0]]));
		trim[0] = '0;
		trim[1] = WIDE'(signed'(mem_r[gmc_pkg::OFF_CELL2_TRIM[6:0]]));
		trim[2] = WIDE'(signed'(mem_r[gmc_pkg::OFF_CELL3_TRIM[6:0]]));
		trim[3] = (cnt == gmc_pkg::CNT_STACK) ? '0 :
			WIDE'(signed'(mem_r[gmc_pkg::OFF_CELL4_TRIM[6:0]]));
		vscale = WIDE'({1'b0, word_at(gmc_pkg::OFF_VOLT_SCALE)});
		iscale = WIDE'({1'b0, word_at(gmc_pkg::OFF_CURR_SCALE)});
	end

	////////////////////////////////////////////////////////////////
	// Node computation, wide to avoid overflow
	logic signed [WIDE-1:0] node_calc;
	always_comb
	begin
		// Signed product so the final shift keeps the sign
		node_calc = ((signed'(WIDE'(i_node_raw)) * gmc_pkg::RAW_SCALE_NUM
			/ gmc_pkg::RAW_SCALE_DEN + zero_trim)
			* (vscale + gmc_pkg::TRIM_WEIGHT * trim[i_node_idx]))
			>>> gmc_pkg::NODE_SHIFT;
	end

	// Node and sense registers
	logic signed [WIDE-1:0] node_r [0:3];
	logic signed [WIDE-1:0] sense_r;
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			for (int k = 0; k < 4; k++)
				node_r[k] <= '0;
		end
		else if (i_node_vld)
			node_r[i_node_idx] <= node_calc;
	end

	// Current and sense voltage
	logic signed [WIDE-1:0] curr_calc;
	logic signed [15:0] curr_r;
	always_comb
	begin
		curr_calc = ((WIDE'(i_sense_raw) + zero_trim) * iscale
			* gmc_pkg::CURR_NUM) / gmc_pkg::CURR_DEN;
	end
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			curr_r <= '0;
			sense_r <= '0;
		end
		else if (i_sense_vld)
		begin
			curr_r <= curr_calc[15:0];
			sense_r <= WIDE'(i_sense_raw) + zero_trim;
		end
	end

	////////////////////////////////////////////////////////////////
	// Reported pack and cell voltages
	logic [15:0] pack_v;
	logic [15:0] cell_v [0:3];
	always_comb
	begin
		case (cnt)
			gmc_pkg::CNT_TWO: pack_v = 16'(node_r[1] - sense_r);
			gmc_pkg::CNT_THREE: pack_v = 16'(node_r[2] - sense_r);
			default: pack_v = 16'(node_r[3] - sense_r);
		endcase
		cell_v[0] = 16'(node_r[0] - sense_r);
		cell_v[1] = 16'(node_r[1] - node_r[0]);
		cell_v[2] = 16'(node_r[2] - node_r[1]);
		cell_v[3] = 16'(node_r[3] - node_r[2]);
		// Cells beyond the count read as zero
		if (cnt == gmc_pkg::CNT_STACK)
		begin
			for (int k = 0; k < 4; k++)
				cell_v[k] = '0;
		end
		else if (cnt == gmc_pkg::CNT_TWO)
		begin
			cell_v[2] = '0;
			cell_v[3] = '0;
		end
		else if (cnt == gmc_pkg::CNT_THREE)
			cell_v[3] = '0;
	end

	////////////////////////////////////////////////////////////////
	// Temperature correction by stored tenths of a degree
	logic signed [15:0] temp_r;
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
			temp_r <= '0;
		else if (i_temp_vld)
			temp_r <= i_temp_raw
				+ 16'(signed'(mem_r[gmc_pkg::OFF_TEMP_CORR[6:0]]));
	end

	////////////////////////////////////////////////////////////////
	// Charge counter offset calibration sequencer
	gmc_pkg::gmc_state_e state_r;
	logic signed [WIDE-1:0] acc_r;
	logic [16:0] smp_r;
	logic [CC_W-1:0] cc_result;
	always_comb
	begin
		cc_result[gmc_pkg::CC_SIGN_BIT] = acc_r[WIDE-1];
		cc_result[gmc_pkg::CC_MAG_W-1:0] = acc_r[WIDE-1] ?
			MAG_W'(-acc_r / CAL_SAMPLES) :
			MAG_W'(acc_r / CAL_SAMPLES);
	end
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state_r <= gmc_pkg::GMC_IDLE;
			acc_r <= '0;
			smp_r <= '0;
		end
		else
		begin
			case (state_r)
				gmc_pkg::GMC_IDLE:
					if (i_maker_cmd_vld && i_maker_cmd == gmc_pkg::CMD_CC_CAL)
					begin
						state_r <= gmc_pkg::GMC_ACCUM;
						acc_r <= '0;
						smp_r <= '0;
					end
				gmc_pkg::GMC_ACCUM:
					if (i_cc_vld)
					begin
						acc_r <= acc_r + WIDE'(i_cc_raw);
						smp_r <= smp_r + 17'h0_0001;
						if (smp_r == 17'(CAL_SAMPLES - 1))
							state_r <= gmc_pkg::GMC_STORE;
					end
				gmc_pkg::GMC_STORE:
					state_r <= gmc_pkg::GMC_IDLE;
				default:
					state_r <= gmc_pkg::GMC_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Store writes; calibration result written back by hardware
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			for (int k = 0; k < 128; k++)
				mem_r[k] <= '0;
		end
		else if (state_r == gmc_pkg::GMC_STORE)
		begin
			mem_r[gmc_pkg::OFF_CC_OFFSET[6:0]] <= cc_result[7:0];
			mem_r[gmc_pkg::OFF_CC_OFFSET[6:0]+7'h01] <= cc_result[15:8];
			mem_r[gmc_pkg::OFF_CC_OFFSET[6:0]+7'h02] <=
				{3'h0, cc_result[CC_W-1:16]};
		end
		else if (i_wr && !i_addr[7])
		begin
			mem_r[i_addr[6:0]] <= i_wdata[7:0];
			mem_r[i_addr[6:0]+7'h01] <= i_wdata[15:8];
		end
	end

	////////////////////////////////////////////////////////////////
	// Read port, one cycle latency
	logic [15:0] rd_val;
	always_comb
	begin
		if (!i_addr[7])
			rd_val = word_at(i_addr);
		else
		begin
			case (i_addr)
				gmc_pkg::OFF_RES_PACK: rd_val = pack_v;
				gmc_pkg::OFF_RES_CELL1: rd_val = cell_v[0];
				gmc_pkg::OFF_RES_CELL2: rd_val = cell_v[1];
				gmc_pkg::OFF_RES_CELL3: rd_val = cell_v[2];
				gmc_pkg::OFF_RES_CELL4: rd_val = cell_v[3];
				gmc_pkg::OFF_RES_CURR: rd_val = curr_r;
				gmc_pkg::OFF_RES_TEMP: rd_val = temp_r;
				gmc_pkg::OFF_RES_STATUS:
					rd_val = {14'h0000, o_image_valid, o_cal_busy};
				default: rd_val = '0;
			endcase
		end
	end
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
			rdata_r <= '0;
		else if (i_rd)
			rdata_r <= rd_val;
		else
			rdata_r <= '0;
	end
	assign o_rdata = rdata_r;

	////////////////////////////////////////////////////////////////
	// Control mode decode, registered outputs
	always_ff @(posedge i_clock or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_charger_checksum_enable <= 1'b0;
			o_five_leds <= 1'b1;
			o_smart_charger_learn <= 1'b0;
			o_broadcast_enable <= 1'b0;
			o_image_valid <= 1'b0;
			o_cal_busy <= 1'b0;
		end
		else
		begin
			o_charger_checksum_enable <= ctrl[gmc_pkg::BIT_CKSUM];
			o_five_leds <= !ctrl[gmc_pkg::BIT_LEDS];
			o_smart_charger_learn <= ctrl[gmc_pkg::BIT_STYLE];
			o_broadcast_enable <= !ctrl[gmc_pkg::BIT_SUPPRESS]
				&& i_mode_bcast_en;
			o_image_valid <=
				word_at(gmc_pkg::OFF_CHECK_ONE) == gmc_pkg::CHECK_ONE_VAL &&
				word_at(gmc_pkg::OFF_CHECK_TWO) == gmc_pkg::CHECK_TWO_VAL;
			o_cal_busy <= state_r != gmc_pkg::GMC_IDLE;
		end
	end
endmodule // gmc_calib

// ---- verif/gmc_calib_props.sv ----
// Checker: mode decode, store readback, image check, calibration start.
// Assumes it is bound onto gmc_calib and sees only its ports.
`timescale 1ns/1ps
module gmc_calib_props
#(
	parameter int RAW_W = 16,
	parameter int CAL_SAMPLES = 16
)
(
	// Clock, reset and register port
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	// Commands and decoded levels
	input wire logic i_maker_cmd_vld,
	input wire logic [15:0] i_maker_cmd,
	input wire logic i_mode_bcast_en,
	input wire logic o_charger_checksum_enable,
	input wire logic o_five_leds,
	input wire logic o_smart_charger_learn,
	input wire logic o_broadcast_enable,
	input wire logic o_image_valid,
	input wire logic o_cal_busy
);
	// One clock domain throughout
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_nrst);
	////////////////////////////////////////////////////////////////
	// Mode write, quiet spell, word round trip
	sequence s_mode_wr;
		i_wr && i_addr == 8'h51;
	endsequence
	sequence s_quiet;
		(!i_wr && i_mode_bcast_en)[*3];
	endsequence
	sequence s_word_rt;
		(i_wr && i_addr == 8'h14) ##1 !i_wr ##1 (i_rd && i_addr == 8'h14);
	endsequence
	// Store updates on the write edge, decode registers one edge later
	a_cksum_decode: assert property (s_mode_wr |-> ##2
		o_charger_checksum_enable == $past(i_wdata[4], 2))
		else $error("checksum enable does not follow mode write");
	a_leds_decode: assert property (s_mode_wr |-> ##2
		o_five_leds == !$past(i_wdata[3], 2))
		else $error("led count does not follow mode write");
	a_style_decode: assert property (s_mode_wr |-> ##2
		o_smart_charger_learn == $past(i_wdata[2], 2))
		else $error("charger style does not follow mode write");
	a_bcast_off: assert property (s_mode_wr ##0 i_wdata[0] |-> ##2
		!o_broadcast_enable)
		else $error("broadcast left on with suppress set");
	a_suppress_holds: assert property (
		(s_mode_wr ##0 i_wdata[0]) ##1 s_quiet |-> !o_broadcast_enable)
		else $error("broadcast request overrode suppress");
	a_word_readback: assert property (s_word_rt |=>
		o_rdata == $past(i_wdata, 3))
		else $error("stored word not read back");
	a_cal_starts: assert property (i_maker_cmd_vld && !o_cal_busy &&
		i_maker_cmd == gmc_pkg::CMD_CC_CAL |-> ##2 o_cal_busy)
		else $error("calibration command did not start");
	a_bad_check: assert property (i_wr && i_addr == 8'h00 &&
		i_wdata != 16'h3c7f |-> ##2 !o_image_valid)
		else $error("image valid with wrong check word");
endmodule // gmc_calib_props

bind gmc_calib gmc_calib_props #(.RAW_W(RAW_W), .CAL_SAMPLES(CAL_SAMPLES))
	u_props
(
	.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_maker_cmd_vld(i_maker_cmd_vld), .i_maker_cmd(i_maker_cmd),
	.i_mode_bcast_en(i_mode_bcast_en),
	.o_charger_checksum_enable(o_charger_checksum_enable),
	.o_five_leds(o_five_leds), .o_smart_charger_learn(o_smart_charger_learn),
	.o_broadcast_enable(o_broadcast_enable), .o_image_valid(o_image_valid),
	.o_cal_busy(o_cal_busy)
);

// ---- verif/gmc_image_rom.sv ----
// Model of the constant store image: one word per even address.
// Assumes the bench copies it into the block over the register port.
`timescale 1ns/1ps
module gmc_image_rom
(
	// Word address and contents
	input wire logic [7:0] i_addr,
	output logic [15:0] o_word
);
	// Image words; the rest are zero, so cell count is 00
	always_comb
	begin
		case (i_addr)
			8'h00: o_word = 16'h3c7f;
			8'h14: o_word = 16'h0031;
			8'h16: o_word = 16'h2a55;
			8'h18: o_word = 16'h0123;
			8'h20: o_word = 16'h000a;
			8'h30: o_word = 16'h0007;
			8'h40: o_word = 16'h0004;
			8'h50: o_word = 16'h0007;
			8'h60: o_word = 16'h1400;
			8'h62: o_word = 16'h04fb;
			8'h64: o_word = 16'h0c08;
			8'h66: o_word = 16'h4e20;
			8'h68: o_word = 16'h4000;
			8'h7e: o_word = 16'ha55a;
			default: o_word = 16'h0000;
		endcase
	end
endmodule // gmc_image_rom

// ---- verif/gmc_calib_bench.sv ----
// Bench: image load, mode bits, cell counts, current, temp, calibration.
// Assumes gmc_calib with two calibration samples and the image model.
`timescale 1ns/1ps
module gmc_calib_bench;
	logic i_clock, i_nrst, i_wr, i_rd, i_node_vld, i_sense_vld, i_temp_vld;
	logic i_cc_vld, i_maker_cmd_vld, i_mode_bcast_en, ck_en, five, smart;
	logic bcast, img_ok, busy;
	logic [7:0] i_addr, img_addr, m;
	logic [15:0] i_wdata, i_maker_cmd, img_word, i_node_raw, o_rdata;
	logic [1:0] i_node_idx;
	logic signed [15:0] i_sense_raw, i_temp_raw;
	logic signed [20:0] i_cc_raw;
	logic [7:0] tbl [7] = '{8'h14, 8'h16, 8'h18, 8'h20, 8'h30, 8'h40, 8'h50};
	int fail_count, cmp_count, p, prv, nc;
	int n [4];
	int vsr = -25;
	// Block and image model
	gmc_calib #(.RAW_W(16), .CAL_SAMPLES(2)) dut
	(
		.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_node_vld(i_node_vld), .i_node_idx(i_node_idx),
		.i_node_raw(i_node_raw), .i_sense_vld(i_sense_vld),
		.i_sense_raw(i_sense_raw), .i_temp_vld(i_temp_vld),
		.i_temp_raw(i_temp_raw), .i_cc_vld(i_cc_vld), .i_cc_raw(i_cc_raw),
		.i_maker_cmd_vld(i_maker_cmd_vld), .i_maker_cmd(i_maker_cmd),
		.i_mode_bcast_en(i_mode_bcast_en), .o_charger_checksum_enable(ck_en),
		.o_five_leds(five), .o_smart_charger_learn(smart),
		.o_broadcast_enable(bcast), .o_image_valid(img_ok), .o_cal_busy(busy)
	);
	gmc_image_rom u_rom (.i_addr(img_addr), .o_word(img_word));
	// 100 ns clock
	initial
	begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic tally_and_finish();
		$display("Compared %0d, failed %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Compare one value and count it
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Register port write and read
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 chk(o_rdata, e);
	endtask
	// Bounded wait on the calibration flag
	task automatic wait_busy(input logic v);
		int k;
		#1 k = 0;
		while (busy !== v && k < 50)
		begin
			@(posedge i_clock);
			#1 k++;
		end
		if (k == 50)
		begin
			fail_count++;
			$display("[ERR] %0t calibration wait ran out", $time);
			tally_and_finish();
		end
	endtask
	// Four node samples, then sense and temperature
	task automatic samples();
		for (int i = 0; i < 4; i++)
		begin
			@(posedge i_clock);
			i_node_vld <= 1'b1;
			i_node_idx <= 2'(i);
			i_node_raw <= 16'(300 * (i + 1));
		end
		@(posedge i_clock);
		{i_node_vld, i_sense_vld, i_temp_vld} <= 3'b011;
		@(posedge i_clock);
		{i_sense_vld, i_temp_vld} <= 2'b00;
		repeat (4) @(posedge i_clock);
	endtask
	// Expected node voltage, zero trim -5, scale 20000
	function automatic int node(input int r, input int t);
		return ((r * 32768 / 1250 - 5) * (20000 + 8 * t)) >>> 15;
	endfunction
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		{i_nrst, i_wr, i_rd, i_node_vld, i_sense_vld, i_temp_vld} = '0;
		{i_cc_vld, i_maker_cmd_vld, i_addr, i_wdata, i_maker_cmd} = '0;
		{i_node_idx, i_node_raw, i_cc_raw, img_addr} = '0;
		{i_mode_bcast_en, i_sense_raw, i_temp_raw} = {1'b1, 16'hffec, 16'h00fa};
		{fail_count, cmp_count} = '0;
		repeat (10) @(posedge i_clock);
		i_nrst <= 1'b1;
		for (int a = 0; a < 128; a += 2)
		begin
			img_addr = 8'(a);
			#1 wr(8'(a), img_word);
		end
		repeat (2) @(posedge i_clock);
		#1 chk(img_ok, 1'b1);
		rd(8'h8e, 16'h0002);
		foreach (tbl[j])
		begin
			img_addr = tbl[j];
			#1 rd(tbl[j], img_word);
		end
		wr(8'h14, 16'h5a5a);
		rd(8'h14, 16'h5a5a);
		for (int i = 0; i < 16; i++)
		begin
			m = {3'b000, i[3:1], 1'b0, i[0]};
			wr(8'h51, {8'h00, m});
			repeat (3) @(posedge i_clock);
			#1 chk(ck_en, m[4]);
			chk(five, !m[3]);
			chk(smart, m[2]);
			chk(bcast, !m[0]);
		end
		@(posedge i_clock);
		i_mode_bcast_en <= 1'b0;
		@(posedge i_clock);
		i_mode_bcast_en <= 1'b1;
		repeat (3) @(posedge i_clock);
		#1 chk(bcast, 1'b0);
		wr(8'h00, 16'h0000);
		repeat (2) @(posedge i_clock);
		#1 chk(img_ok, 1'b0);
		wr(8'h00, 16'h3c7f);
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h3e, {6'h00, 2'(c), 8'h00});
			samples();
			for (int j = 0; j < 4; j++)
				n[j] = node(300 * (j + 1), (c == 0 && j == 3) ? 0 : 4 * j);
			p = (c == 0 || c == 3) ? n[3] : n[c];
			rd(8'h80, 16'(p - vsr));
			nc = (c == 0) ? 0 : c + 1;
			prv = vsr;
			for (int j = 1; j <= 4; j++)
			begin
				rd(8'(128 + 2 * j), (j > nc) ? 16'h0000 : 16'(n[j-1] - prv));
				prv = n[j-1];
			end
		end
		rd(8'h8a, 16'h9e58);
		rd(8'h8c, 16'h010e);
		@(posedge i_clock);
		{i_maker_cmd_vld, i_maker_cmd} <= {1'b1, gmc_pkg::CMD_CC_CAL};
		@(posedge i_clock);
		i_maker_cmd_vld <= 1'b0;
		wait_busy(1'b1);
		for (int j = 0; j < 2; j++)
		begin
			@(posedge i_clock);
			{i_cc_vld, i_cc_raw} <= {1'b1, 21'(-300 - 2 * j)};
		end
		@(posedge i_clock);
		i_cc_vld <= 1'b0;
		wait_busy(1'b0);
		rd(8'h5e, 16'h012d);
		rd(8'h60, 16'h1410);
		rd(8'hf0, 16'h0000);
		tally_and_finish();
	end
endmodule // gmc_calib_bench
